// File: sbcl_cfg_mem.sv
`timescale 1ns/1ps
// small per-channel settings store, one write port muxed by caller, registered read
module sbcl_cfg_mem #(
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [7:0]    wdata,
    input  wire logic [AW-1:0] raddr,
    output logic [7:0]         rdata
);
    logic [7:0] mem [DEPTH];

    // no reset: contents are defined by the EEPROM load or by software
    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : sbcl_cfg_mem

// File: sbcl_eeprom_model.sv
`timescale 1ns/1ps
// eeprom stand-in: takes an offset write, then serves bytes of image until the host nacks
module sbcl_eeprom_model (
    input  wire logic         scl,
    input  wire logic         sda,
    input  wire logic         ackEn,
    input  wire logic [127:0] image,
    output logic              ackDrive,
    output logic [7:0]        firstByte,
    output int                nHostAcks
);
    logic [7:0] shiftIn;
    logic [7:0] outByte;
    logic [3:0] ptr;
    logic       hostNack;
    int         nStarts;

    // one byte in on the rising clock edges, then the ack bit held for one bit time
    task automatic getByte(input logic ack);
        repeat (8) @(posedge scl) shiftIn = {shiftIn[6:0], sda};
        @(negedge scl);
        ackDrive = ack;
        @(negedge scl);
    endtask : getByte

    // with ackEn low the address is refused, which is the quick way to end a load
    initial
    begin
        ackDrive  = 1'h0;
        firstByte = 8'h00;
        nStarts   = 0;
        nHostAcks = 0;
        ptr       = 4'h0;
        forever
        begin
            @(negedge sda iff scl === 1'h1);
            nStarts++;
            getByte(ackEn);
            if (nStarts == 1)
                firstByte = shiftIn;
            if (ackEn && shiftIn[0])
            begin
                hostNack = 1'h0;
                while (!hostNack)
                begin
                    outByte = image[8*ptr +: 8];
                    repeat (8)
                    begin
                        ackDrive = !outByte[7];
                        outByte  = {outByte[6:0], 1'h0};
                        @(negedge scl);
                    end
                    ackDrive = 1'h0;
                    @(posedge scl) hostNack = sda;
                    if (!hostNack)
                        nHostAcks++;
                    ptr++;
                    @(negedge scl);
                end
            end
            else
            begin
                ackDrive = 1'h0;
                if (ackEn)
                begin
                    getByte(1'h1);
                    ackDrive = 1'h0;
                    ptr = shiftIn[3:0];
                end
            end
        end
    end
endmodule : sbcl_eeprom_model

// File: sbcl_loader.sv
`timescale 1ns/1ps
module sbcl_loader #(
    parameter int QUARTER = sbcl_pkg::QUARTER_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        masterMode,
    input  wire logic        loadGrantN,
    output logic             loadDoneN,
    input  wire logic [3:0]  addrStrap,
    input  wire logic        serial_bus_clock_line_i,
    output logic             serial_bus_clock_line_oe,
    input  wire logic        sdaI,
    output logic             sdaOe,
    output logic             busMaster,
    output logic [6:0]       slaveAddr,
    output logic             slaveEnable,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);
    typedef enum {ST_STRAP, ST_WAIT, ST_START, ST_BYTE, ST_ACK, ST_RSTART, ST_RDBYTE,
                  ST_MACK, ST_STOP, ST_DONE} sbcl_state_t;

    sbcl_state_t state;
    logic [1:0]  grantSync;
    logic [1:0]  modeSync;
    logic [3:0]  strapMeta;
    logic [3:0]  strapSync;
    logic [1:0]  settle;
    logic        sclStall;
    logic [1:0]  sclSync;
    logic [1:0]  sdaSync;
    logic [15:0] divCnt;
    logic        tick;
    logic [1:0]  phase;
    logic [7:0]  shifter;
    logic [2:0]  bitCnt;
    logic [1:0]  byteIdx;
    logic [4:0]  wordCnt;
    logic        loadErr;
    logic        strapTaken;
    logic        memWe;
    logic [3:0]  memWaddr;
    logic [7:0]  memWdata;
    logic [7:0]  memRdata;
    logic        apbWrite;
    logic        apbCfg;
    logic        ackErr;

    // pins come from outside mclk: two flops before use
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            grantSync <= 2'h3;
            modeSync  <= 2'h0;
            strapMeta <= 4'h0;
            strapSync <= 4'h0;
            settle    <= 2'h0;
            sclSync   <= 2'h3;
            sdaSync   <= 2'h3;
        end
        else
        begin
            grantSync <= {grantSync[0], loadGrantN};
            modeSync  <= {modeSync[0], masterMode};
            strapMeta <= addrStrap;
            strapSync <= strapMeta;
            settle    <= {settle[0], 1'b1}; // high once every strap has passed both stages
            sclSync   <= {sclSync[0], serial_bus_clock_line_i};
            sdaSync   <= {sdaSync[0], sdaI};
        end
    end

    // quarter-bit enable for the bus clock; runs free, only the sequencer listens
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            divCnt <= 16'h0000;
            tick   <= 1'b0;
        end
        else
        begin
            tick <= 1'b0;
            if (divCnt == 16'(QUARTER - 1))
            begin
                divCnt <= 16'h0000;
                tick   <= 1'b1;
            end
            else
            begin
                divCnt <= divCnt + 16'h0001;
            end
        end
    end

    // strap capture once the synchronisers hold the real pin levels, not their reset values
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            strapTaken <= 1'b0;
            slaveAddr  <= 7'h00;
        end
        else if (!strapTaken && settle[1])
        begin
            strapTaken <= 1'b1;
            if (!modeSync[1] && grantSync[1])
            begin
                slaveAddr <= sbcl_pkg::ADDR_TEST; // test address, straps ignored
            end
            else
            begin
                slaveAddr <= sbcl_pkg::ADDR_BASE + {3'h0, strapSync};
            end
        end
    end

    // loader sequencer: random read of the eeprom from the start offset
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            state     <= ST_STRAP;
            phase     <= 2'h0;
            shifter   <= 8'h00;
            bitCnt    <= 3'h0;
            byteIdx   <= 2'h0;
            wordCnt   <= 5'h00;
            loadErr   <= 1'b0;
            busMaster <= 1'b0;
            loadDoneN <= 1'b1; // held high until load ends
            serial_bus_clock_line_oe <= 1'b0;
            sdaOe     <= 1'b0;
            memWe     <= 1'b0;
            memWaddr  <= 4'h0;
            memWdata  <= 8'h00;
        end
        else
        begin
            memWe <= 1'b0;
            case (state)
                ST_STRAP:
                begin
                    // mode strap is only trusted once it has passed both flops
                    if (settle[1])
                        state <= modeSync[1] ? ST_WAIT : ST_DONE;
                end
                ST_WAIT:
                begin
                    if (!grantSync[1]) // grant seen low: take the bus
                    begin
                        busMaster <= 1'b1;
                        state     <= ST_START;
                        phase     <= 2'h0;
                        byteIdx   <= 2'h0;
                        shifter   <= {sbcl_pkg::EEPROM_ADDR, 1'b0};
                    end
                end
                ST_START, ST_RSTART:
                begin
                    if (tick && !sclStall)
                    begin
                        phase <= phase + 2'h1;
                        case (phase)
                            2'h0: sdaOe <= 1'b0;
                            2'h1: serial_bus_clock_line_oe <= 1'b0;
                            2'h2: sdaOe <= 1'b1;
                            default:
                            begin
                                serial_bus_clock_line_oe <= 1'b1;
                                bitCnt <= 3'h7;
                                state  <= ST_BYTE;
                            end
                        endcase
                    end
                end
                ST_BYTE, ST_RDBYTE, ST_ACK, ST_MACK:
                begin
                    if (tick && !sclStall)
                    begin
                        phase <= phase + 2'h1;
                        case (phase)
                            2'h0:
                            begin
                                // same two lines as the slave side uses
                                if (state == ST_BYTE)
                                    sdaOe <= ~shifter[7];
                                else if (state == ST_MACK)
                                    sdaOe <= (wordCnt != 5'(sbcl_pkg::CFG_WORDS - 1)); // nack the last byte
                                else
                                    sdaOe <= 1'b0;
                            end
                            2'h1: serial_bus_clock_line_oe <= 1'b0;
                            2'h2:
                            begin
                                if (state == ST_RDBYTE)
                                    shifter <= {shifter[6:0], sdaSync[1]};
                                if (state == ST_ACK && sdaSync[1])
                                    loadErr <= 1'b1;
                            end
                            default:
                            begin
                                serial_bus_clock_line_oe <= 1'b1;
                                if (state == ST_BYTE || state == ST_RDBYTE)
                                begin
                                    if (state == ST_BYTE)
                                        shifter <= {shifter[6:0], 1'b0};
                                    if (bitCnt == 3'h0)
                                        state <= (state == ST_BYTE) ? ST_ACK : ST_MACK;
                                    bitCnt <= bitCnt - 3'h1;
                                end
                                else if (state == ST_ACK)
                                begin
                                    byteIdx <= byteIdx + 2'h1;
                                    bitCnt  <= 3'h7;
                                    if (loadErr)
                                        state <= ST_STOP;
                                    else if (byteIdx == 2'h0)
                                    begin
                                        shifter <= sbcl_pkg::EEPROM_START;
                                        state   <= ST_BYTE;
                                    end
                                    else if (byteIdx == 2'h1)
                                    begin
                                        shifter <= {sbcl_pkg::EEPROM_ADDR, 1'b1};
                                        state   <= ST_RSTART;
                                    end
                                    else
                                        state <= ST_RDBYTE;
                                end
                                else
                                begin
                                    // each channel has its own words in the store
                                    memWe    <= 1'b1;
                                    memWaddr <= wordCnt[3:0];
                                    memWdata <= shifter;
                                    wordCnt  <= wordCnt + 5'h01;
                                    bitCnt   <= 3'h7;
                                    state    <= (wordCnt == 5'(sbcl_pkg::CFG_WORDS - 1)) ? ST_STOP : ST_RDBYTE;
                                end
                            end
                        endcase
                    end
                end
                ST_STOP:
                begin
                    if (tick && !sclStall)
                    begin
                        phase <= phase + 2'h1;
                        case (phase)
                            2'h0: sdaOe <= 1'b1;
                            2'h1: serial_bus_clock_line_oe <= 1'b0;
                            2'h2: sdaOe <= 1'b0;
                            default:
                            begin
                                busMaster <= 1'b0; // release bus
                                loadDoneN <= 1'b0; // stays low until reset
                                state     <= ST_DONE;
                            end
                        endcase
                    end
                end
                ST_DONE:
                begin
                    serial_bus_clock_line_oe <= 1'b0;
                    sdaOe <= 1'b0;
                end
                default: state <= ST_STRAP;
            endcase
        end
    end

    // a slave holding the clock low stretches the high phase instead of losing a bit
    assign sclStall = (phase == 2'h2) && !sclSync[1];

    // slave accepted only once loading is over
    assign slaveEnable = (state == ST_DONE);

    // apb slave: zero wait, settings words writable by the host after loading
    assign pready   = 1'b1;
    assign apbCfg   = (paddr >= 12'(sbcl_pkg::APB_CFG_BASE)) &&
                      (paddr < 12'(sbcl_pkg::APB_CFG_BASE + 4 * sbcl_pkg::CFG_WORDS));
    assign apbWrite = psel && penable && pwrite && apbCfg && slaveEnable;
    assign ackErr   = psel && penable && !(apbCfg || paddr == 12'(sbcl_pkg::APB_STATUS) ||
                      paddr == 12'(sbcl_pkg::APB_ADDR));
    assign pslverr  = ackErr;

    sbcl_cfg_mem #(
        .DEPTH (sbcl_pkg::CFG_WORDS),
        .AW    (sbcl_pkg::CFG_AW)
    ) u_mem (
        .clk   (mclk),
        .we    (memWe | apbWrite),
        .waddr (apbWrite ? paddr[5:2] : memWaddr),
        .wdata (apbWrite ? pwdata[7:0] : memWdata),
        .raddr (paddr[5:2]),
        .rdata (memRdata)
    );

    // read mux; settings word comes from the registered store, so hosts read twice
    always_comb
    begin
        prdata = 32'h0000_0000;
        if (apbCfg)
            prdata = {24'h000000, memRdata};
        else if (paddr == 12'(sbcl_pkg::APB_STATUS))
            prdata = {28'h0000000, loadErr, busMaster, ~loadDoneN, slaveEnable};
        else if (paddr == 12'(sbcl_pkg::APB_ADDR))
            prdata = {25'h0, slaveAddr};
    end
endmodule : sbcl_loader

// File: sbcl_loader_assertions.sv
`timescale 1ns/1ps
// port-level checks on the loader; all on mclk, quiet while reset is high
module sbcl_loader_assertions (
    input wire logic       mclk,
    input wire logic       reset,
    input wire logic       masterMode,
    input wire logic       loadGrantN,
    input wire logic       loadDoneN,
    input wire logic [3:0] addrStrap,
    input wire logic       serial_bus_clock_line_oe,
    input wire logic       busMaster,
    input wire logic [6:0] slaveAddr,
    input wire logic       slaveEnable
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // the two ends of the load phase
    sequence busTaken;
        $rose(busMaster);
    endsequence
    sequence busFreed;
        $fell(busMaster);
    endsequence
    // grant passes a two-stage synchroniser and one sequencer edge, so look three samples back
    AST_TAKE_ON_GRANT: assert property (busTaken |-> masterMode && !$past(loadGrantN, 3))
        else $error("bus taken without a grant");
    AST_DONE_AFTER_LOAD: assert property (busFreed |-> ##[0:4] !loadDoneN)
        else $error("load ended without done");
    AST_DONE_STICKY: assert property (!loadDoneN |=> !loadDoneN)
        else $error("done went back high");
    AST_DONE_HIGH_LOADING: assert property (busMaster |-> loadDoneN)
        else $error("done low while loading");
    AST_QUIET_AS_SLAVE: assert property (!busMaster && !$past(busMaster) |-> !serial_bus_clock_line_oe)
        else $error("clock line driven outside the load");
    AST_NO_SLAVE_LOADING: assert property (busMaster |-> !slaveEnable)
        else $error("slave enabled while loading");
    AST_SLAVE_NEVER_MASTERS: assert property (!masterMode |-> !busMaster)
        else $error("bus taken in slave mode");
    AST_ADDR_LATCH: assert property (slaveEnable |-> slaveAddr == ((!masterMode && loadGrantN) ?
        sbcl_pkg::ADDR_TEST : sbcl_pkg::ADDR_BASE + 7'(addrStrap)))
        else $error("slave address wrong");
    AST_ADDR_HELD: assert property (slaveEnable |=> $stable(slaveAddr))
        else $error("slave address moved");
endmodule : sbcl_loader_assertions

bind sbcl_loader sbcl_loader_assertions u_chk (.mclk, .reset, .masterMode, .loadGrantN, .loadDoneN,
    .addrStrap, .serial_bus_clock_line_oe, .busMaster, .slaveAddr, .slaveEnable);

// File: sbcl_pkg.sv
package sbcl_pkg;
    localparam int          NUM_CHANNELS   = 4;
    localparam int          REGS_PER_CHAN  = 4;
    localparam int          CFG_WORDS      = NUM_CHANNELS * REGS_PER_CHAN;
    localparam int          CFG_AW         = 4;
    localparam logic [6:0]  ADDR_BASE      = 7'h18;
    localparam logic [6:0]  ADDR_TEST      = 7'h18;
    localparam logic [6:0]  EEPROM_ADDR    = 7'h50;
    localparam logic [7:0]  EEPROM_START   = 8'h00;
    localparam int          CLK_MHZ        = 125;
    localparam int          SCL_KHZ        = 100;
    localparam int          QUARTER_CYCLES = (CLK_MHZ * 1000) / (SCL_KHZ * 4);
    localparam int          APB_CTRL       = 12'h000;
    localparam int          APB_STATUS     = 12'h004;
    localparam int          APB_ADDR       = 12'h008;
    localparam int          APB_CFG_BASE   = 12'h040;
    localparam logic [31:0] APB_CTRL_RST   = 32'h0000_0000;
endpackage : sbcl_pkg

// File: smbus_boot_config_loader_bench.sv
`timescale 1ns/1ps
// slave set-up, test address, a master-mode load that the eeprom refuses, then a full load
module smbus_boot_config_loader_bench;
    logic        mclk, reset, masterMode, loadGrantN, psel, penable, pwrite, pready, pslverr, err;
    logic        loadDoneN, sclOe, sdaOe, busMaster, slaveEnable, eeAck, eeAckEn;
    logic [127:0] image;
    logic [3:0]  addrStrap;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [6:0]  slaveAddr;
    logic [7:0]  firstByte;
    wire         sclLine = !sclOe;
    wire         sdaLine = !(sdaOe || eeAck);
    int          err_count, n_checks, seed, i, k, cfgModel[16], nHostAcks;

    // short quarter bit so that a full sixteen-byte load fits the run
    sbcl_loader #(.QUARTER(8)) uut (.mclk, .reset, .masterMode, .loadGrantN, .loadDoneN, .addrStrap,
        .serial_bus_clock_line_i(sclLine), .serial_bus_clock_line_oe(sclOe), .sdaI(sdaLine), .sdaOe,
        .busMaster, .slaveAddr, .slaveEnable, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr);
    sbcl_eeprom_model eeprom (.scl(sclLine), .sda(sdaLine), .ackEn(eeAckEn), .image, .ackDrive(eeAck),
        .firstByte, .nHostAcks);

    // free-running 125 MHz clock
    initial
    begin
        mclk = 1'h0;
        forever #4 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; read data and error taken at the edge that sees pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        @(posedge mclk);
        // ends at the first edge that sees pready high, which the loader ties high
        while (pready !== 1'h1)
            @(posedge mclk);
        q = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    // settings store answers a cycle late, so read twice
    task automatic cfgRead(input int c);
        apb(1'h0, 12'(sbcl_pkg::APB_CFG_BASE + 4 * c), 32'h0);
        apb(1'h0, 12'(sbcl_pkg::APB_CFG_BASE + 4 * c), 32'h0);
        chk(q[7:0], cfgModel[c][7:0]);
    endtask : cfgRead

    task automatic restart(input logic mm, input logic g, input logic [3:0] s);
        @(posedge mclk);
        reset <= 1'h1;
        masterMode <= mm;
        loadGrantN <= g;
        addrStrap <= s;
        repeat (12) @(posedge mclk);
        reset <= 1'h0;
        repeat (4) @(posedge mclk);
    endtask : restart

    task automatic waitBus(input logic lvl, input int lim);
        int n = 0;
        while (busMaster !== lvl && n < lim)
        begin
            n++;
            @(posedge mclk);
        end
    endtask : waitBus

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish

    // hang guard, well past the expected run
    initial
    begin
        #200000;
        err_count++;
        $display("ERROR %0t watchdog", $time);
        tally_and_finish;
    end

    initial
    begin
        seed = 61233;
        {masterMode, loadGrantN, addrStrap, psel, penable, pwrite, paddr, pwdata, eeAckEn} = '0;
        reset = 1'h1;
        for (i = 0; i < 2; i++)
        begin
            k = $random(seed);
            restart(1'h0, 1'h0, k[3:0]);
            chk(slaveAddr, sbcl_pkg::ADDR_BASE + k[3:0]);
            chk({busMaster, slaveEnable}, 2'h1);
        end
        for (i = 0; i < 16; i++)
        begin
            cfgModel[i] = $random(seed) & 255;
            apb(1'h1, 12'(sbcl_pkg::APB_CFG_BASE + 4 * i), 32'(cfgModel[i]));
        end
        for (i = 0; i < 16; i++)
            cfgRead(i);
        apb(1'h0, 12'h100, 32'h0);
        chk(err, 1'h1);
        apb(1'h0, 12'(sbcl_pkg::APB_ADDR), 32'h0);
        chk(q[6:0], sbcl_pkg::ADDR_BASE + k[3:0]);
        restart(1'h0, 1'h1, 4'hF);
        chk(slaveAddr, sbcl_pkg::ADDR_TEST);
        // master mode sits idle without a grant and refuses settings writes
        restart(1'h1, 1'h1, k[3:0]);
        repeat (300) @(posedge mclk);
        chk({busMaster, slaveEnable, loadDoneN}, 3'h1);
        apb(1'h1, 12'(sbcl_pkg::APB_CFG_BASE), 32'(~cfgModel[0]));
        cfgRead(0);
        loadGrantN <= 1'h0;
        waitBus(1'h1, 20);
        chk(busMaster, 1'h1);
        waitBus(1'h0, 40000);
        repeat (8) @(posedge mclk);
        chk(firstByte, {sbcl_pkg::EEPROM_ADDR, 1'h0});
        chk({busMaster, slaveEnable, loadDoneN}, 3'h2);
        apb(1'h0, 12'(sbcl_pkg::APB_STATUS), 32'h0);
        chk(q[3:0], 4'hB);
        cfgModel[0] = $random(seed) & 255;
        apb(1'h1, 12'(sbcl_pkg::APB_CFG_BASE), 32'(cfgModel[0]));
        cfgRead(0);
        // full load: eeprom acks, sixteen bytes land in the settings store
        eeAckEn = 1'h1;
        image = {$random(seed), $random(seed), $random(seed), $random(seed)};
        restart(1'h1, 1'h0, k[3:0]);
        chk(slaveAddr, sbcl_pkg::ADDR_BASE + k[3:0]);
        waitBus(1'h1, 20);
        chk(busMaster, 1'h1);
        waitBus(1'h0, 20000); // host keeps off the bus while loading
        repeat (8) @(posedge mclk);
        chk(nHostAcks, 32'(sbcl_pkg::CFG_WORDS - 1));
        chk({busMaster, slaveEnable, loadDoneN}, 3'h2);
        apb(1'h0, 12'(sbcl_pkg::APB_STATUS), 32'h0);
        chk(q[3:0], 4'h3);
        for (i = 0; i < 16; i++)
        begin
            cfgModel[i] = image[8*i +: 8];
            cfgRead(i);
        end
        tally_and_finish;
    end
endmodule : smbus_boot_config_loader_bench
